// [rtl/spc_capture.v]
// paged register file and two capture channels sharing one interrupt line
`timescale 1ns/1ps
// Overview of operation
// - measure high time and period in ticks
// - interrupt after rising edge ends measurement
// - both channels share one interrupt line
// - done flag holds until clear bit written
// - page 0 external, page 1 internal
// - external control bit 7 enables channel
// - external bit 6 set on completion
// - bit 4 picks pin a or b
// - external bit 3 write-one clears done
// - external clock divide 4 to 512
// - external period count sixteen bits split
// - external high count sixteen bits split
// - internal control bit 7 enables channel
// - internal bit 6 set on completion
// - internal bit 4 is measured level
// - internal bit 3 write-one clears done
// - internal clock offers same eight divisions
// - internal counts sixteen bits split
module spc_capture #(
  parameter COUNT_WIDTH = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] register_page_select,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  input wire capture_input_pin_a,
  input wire capture_input_pin_b,
  output wire capture_irq
);
  `include "spc_defs.vh"

  // reset image of a control byte, sliced per field so no bits are dropped
  localparam [7:0] CTRL_RESET = `SPC_CONTROL_RESET;

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg pin_a_meta_reg;
  reg pin_a_sync_reg;
  reg pin_b_meta_reg;
  reg pin_b_sync_reg;
  reg ext_channel_enable;
  reg ext_measure_done;
  reg ext_input_pin_select;
  reg [2:0] ext_count_clock_select;
  reg int_channel_enable;
  reg int_measure_done;
  reg int_signal_level_bit;
  reg [2:0] int_count_clock_select;
  reg [COUNT_WIDTH-1:0] ext_period_count_reg;
  reg [COUNT_WIDTH-1:0] ext_high_count_reg;
  reg [COUNT_WIDTH-1:0] int_period_count_reg;
  reg [COUNT_WIDTH-1:0] int_high_count_reg;
  reg [7:0] rdata_next;
  wire ext_done_pulse;
  wire int_done_pulse;
  wire [COUNT_WIDTH-1:0] ext_high_latched;
  wire [COUNT_WIDTH-1:0] ext_period_latched;
  wire [COUNT_WIDTH-1:0] int_high_latched;
  wire [COUNT_WIDTH-1:0] int_period_latched;
  wire ext_signal;
  wire page_ext;
  wire page_int;
  wire ext_done_clear;
  wire int_done_clear;
  wire int_done_clear_alias;

  // reset released through two flops, asserted at once
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // capture pins are asynchronous; only the second flop is read
  always @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      pin_a_meta_reg <= 1'b0;
      pin_a_sync_reg <= 1'b0;
      pin_b_meta_reg <= 1'b0;
      pin_b_sync_reg <= 1'b0;
    end else if (clk_en) begin
      pin_a_meta_reg <= capture_input_pin_a;
      pin_a_sync_reg <= pin_a_meta_reg;
      pin_b_meta_reg <= capture_input_pin_b;
      pin_b_sync_reg <= pin_b_meta_reg;
    end
  end

  assign ext_signal = ext_input_pin_select ? pin_a_sync_reg : pin_b_sync_reg;

  // both channels answer at the same offsets, page picks which
  assign page_ext = (register_page_select == `SPC_PAGE_EXT);
  assign page_int = (register_page_select == `SPC_PAGE_INT);

  assign ext_done_clear = sfr_wr && page_ext && sfr_addr == `SPC_ADDR_CONTROL && sfr_wdata[`SPC_BIT_CLEAR];
  assign int_done_clear = sfr_wr && page_int && sfr_addr == `SPC_ADDR_CONTROL && sfr_wdata[`SPC_BIT_CLEAR];
  assign int_done_clear_alias = int_done_clear;

  spc_channel #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) u_ext_channel (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_reg),
    .clk_en(clk_en),
    .enable(ext_channel_enable),
    .signal_level(ext_signal),
    .clock_select(ext_count_clock_select),
    .capture_pulse(ext_done_pulse),
    .high_capture_reg(ext_high_latched),
    .period_capture_reg(ext_period_latched)
  );

  spc_channel #(
    .COUNT_WIDTH(COUNT_WIDTH)
  ) u_int_channel (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_reg),
    .clk_en(clk_en),
    .enable(int_channel_enable),
    .signal_level(int_signal_level_bit),
    .clock_select(int_count_clock_select),
    .capture_pulse(int_done_pulse),
    .high_capture_reg(int_high_latched),
    .period_capture_reg(int_period_latched)
  );

  // control registers and done flags; a completion beats a same-cycle clear
  always @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ext_channel_enable <= CTRL_RESET[`SPC_BIT_ENABLE];
      ext_measure_done <= 1'b0;
      ext_input_pin_select <= CTRL_RESET[`SPC_BIT_SOURCE];
      ext_count_clock_select <= CTRL_RESET[`SPC_CKS_MSB:`SPC_CKS_LSB];
      int_channel_enable <= CTRL_RESET[`SPC_BIT_ENABLE];
      int_measure_done <= 1'b0;
      int_signal_level_bit <= CTRL_RESET[`SPC_BIT_SOURCE];
      int_count_clock_select <= CTRL_RESET[`SPC_CKS_MSB:`SPC_CKS_LSB];
    end else if (clk_en) begin
      if (sfr_wr && sfr_addr == `SPC_ADDR_CONTROL && page_ext) begin
        ext_channel_enable <= sfr_wdata[`SPC_BIT_ENABLE];
        ext_input_pin_select <= sfr_wdata[`SPC_BIT_SOURCE];
        ext_count_clock_select <= sfr_wdata[`SPC_CKS_MSB:`SPC_CKS_LSB];
      end
      if (sfr_wr && sfr_addr == `SPC_ADDR_CONTROL && page_int) begin
        int_channel_enable <= sfr_wdata[`SPC_BIT_ENABLE];
        int_signal_level_bit <= sfr_wdata[`SPC_BIT_SOURCE];
        int_count_clock_select <= sfr_wdata[`SPC_CKS_MSB:`SPC_CKS_LSB];
      end
      if (ext_done_pulse) begin
        ext_measure_done <= 1'b1;
      end else if (ext_done_clear) begin
        ext_measure_done <= 1'b0;
      end
      if (int_done_pulse) begin
        int_measure_done <= 1'b1;
      end else if (int_done_clear_alias) begin
        int_measure_done <= 1'b0;
      end
    end
  end

  // count registers: hardware latch on completion, otherwise software may write bytes
  always @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ext_period_count_reg <= `SPC_COUNT_RESET;
      ext_high_count_reg <= `SPC_COUNT_RESET;
      int_period_count_reg <= `SPC_COUNT_RESET;
      int_high_count_reg <= `SPC_COUNT_RESET;
    end else if (clk_en) begin
      if (ext_done_pulse) begin
        ext_period_count_reg <= ext_period_latched;
        ext_high_count_reg <= ext_high_latched;
      end else if (sfr_wr && page_ext) begin
        case (sfr_addr)
          `SPC_ADDR_PERIOD_LOW: ext_period_count_reg[7:0] <= sfr_wdata;
          `SPC_ADDR_PERIOD_HIGH: ext_period_count_reg[15:8] <= sfr_wdata;
          `SPC_ADDR_HIGH_LOW: ext_high_count_reg[7:0] <= sfr_wdata;
          `SPC_ADDR_HIGH_HIGH: ext_high_count_reg[15:8] <= sfr_wdata;
          default: begin
          end
        endcase
      end
      if (int_done_pulse) begin
        int_period_count_reg <= int_period_latched;
        int_high_count_reg <= int_high_latched;
      end else if (sfr_wr && page_int) begin
        case (sfr_addr)
          `SPC_ADDR_PERIOD_LOW: int_period_count_reg[7:0] <= sfr_wdata;
          `SPC_ADDR_PERIOD_HIGH: int_period_count_reg[15:8] <= sfr_wdata;
          `SPC_ADDR_HIGH_LOW: int_high_count_reg[7:0] <= sfr_wdata;
          `SPC_ADDR_HIGH_HIGH: int_high_count_reg[15:8] <= sfr_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; clear bit is write-only and reads zero
  always @* begin
    rdata_next = 8'h00;
    if (page_ext) begin
      case (sfr_addr)
        `SPC_ADDR_PERIOD_LOW: rdata_next = ext_period_count_reg[7:0];
        `SPC_ADDR_PERIOD_HIGH: rdata_next = ext_period_count_reg[15:8];
        `SPC_ADDR_HIGH_LOW: rdata_next = ext_high_count_reg[7:0];
        `SPC_ADDR_HIGH_HIGH: rdata_next = ext_high_count_reg[15:8];
        `SPC_ADDR_CONTROL: rdata_next = {ext_channel_enable, ext_measure_done, 1'b0,
                                         ext_input_pin_select, 1'b0, ext_count_clock_select};
        default: rdata_next = 8'h00;
      endcase
    end else if (page_int) begin
      case (sfr_addr)
        `SPC_ADDR_PERIOD_LOW: rdata_next = int_period_count_reg[7:0];
        `SPC_ADDR_PERIOD_HIGH: rdata_next = int_period_count_reg[15:8];
        `SPC_ADDR_HIGH_LOW: rdata_next = int_high_count_reg[7:0];
        `SPC_ADDR_HIGH_HIGH: rdata_next = int_high_count_reg[15:8];
        `SPC_ADDR_CONTROL: rdata_next = {int_channel_enable, int_measure_done, 1'b0,
                                         int_signal_level_bit, 1'b0, int_count_clock_select};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // registered read data, one cycle after the read strobe
  always @(posedge clk_sys or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en && sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end

  // one combined level request; handler tells the channels apart by the flags
  assign capture_irq = ext_measure_done | int_measure_done;
endmodule

// [common/spc_defs.vh]
// register addresses, field positions, reset values and count constants for the pulse capture block
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH
`define SPC_ADDR_PERIOD_LOW 8'hD9
`define SPC_ADDR_PERIOD_HIGH 8'hDA
`define SPC_ADDR_HIGH_LOW 8'hDB
`define SPC_ADDR_HIGH_HIGH 8'hDC
`define SPC_ADDR_CONTROL 8'hDD
`define SPC_PAGE_EXT 8'h00
`define SPC_PAGE_INT 8'h01
`define SPC_BIT_ENABLE 7
`define SPC_BIT_DONE 6
`define SPC_BIT_SOURCE 4
`define SPC_BIT_CLEAR 3
`define SPC_CKS_MSB 2
`define SPC_CKS_LSB 0
`define SPC_CONTROL_RESET 8'h03
`define SPC_COUNT_RESET 16'h0000
`define SPC_PRESCALE_WIDTH 9
`endif

// [rtl/spc_channel.v]
// one capture channel: tick prescaler, edge detector, high and period counters
`timescale 1ns/1ps
module spc_channel #(
  parameter COUNT_WIDTH = 16
) (
  input wire clk_sys,
  input wire rst_sync_n,
  input wire clk_en,
  input wire enable,
  input wire signal_level,
  input wire [2:0] clock_select,
  output reg capture_pulse,
  output reg [COUNT_WIDTH-1:0] high_capture_reg,
  output reg [COUNT_WIDTH-1:0] period_capture_reg
);
  `include "spc_defs.vh"

  localparam ST_IDLE = 2'b00;
  localparam ST_HIGH = 2'b01;
  localparam ST_LOW = 2'b10;

  reg [`SPC_PRESCALE_WIDTH-1:0] prescale_reg;
  reg level_prev_reg;
  reg [1:0] state_reg;
  reg [COUNT_WIDTH-1:0] high_cnt_reg;
  reg [COUNT_WIDTH-1:0] period_cnt_reg;
  wire tick;
  wire rise;
  wire fall;

  // terminal count of divide by 4 << code, less one; at code 7 the 9-bit wrap still gives 511
  function [`SPC_PRESCALE_WIDTH-1:0] div_last;
    input [2:0] code;
    begin
      div_last = ({{(`SPC_PRESCALE_WIDTH-3){1'b0}}, 3'h4} << code) - 9'h001;
    end
  endfunction

  assign tick = (prescale_reg == div_last(clock_select));
  assign rise = signal_level & ~level_prev_reg;
  assign fall = ~signal_level & level_prev_reg;

  // prescaler free runs while enabled and is held at zero when disabled, so a clock-select change takes effect within one tick
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prescale_reg <= 9'h000;
    end else if (clk_en) begin
      if (!enable || tick || prescale_reg > div_last(clock_select)) begin
        prescale_reg <= 9'h000;
      end else begin
        prescale_reg <= prescale_reg + 9'h001;
      end
    end
  end

  // measurement sequencer; counters saturate rather than wrap on slow inputs
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      level_prev_reg <= 1'b0;
      state_reg <= ST_IDLE;
      high_cnt_reg <= {COUNT_WIDTH{1'b0}};
      period_cnt_reg <= {COUNT_WIDTH{1'b0}};
      high_capture_reg <= {COUNT_WIDTH{1'b0}};
      period_capture_reg <= {COUNT_WIDTH{1'b0}};
      capture_pulse <= 1'b0;
    end else if (clk_en) begin
      level_prev_reg <= signal_level;
      capture_pulse <= 1'b0;
      if (tick && period_cnt_reg != {COUNT_WIDTH{1'b1}}) begin
        period_cnt_reg <= period_cnt_reg + 1'b1;
      end
      if (tick && state_reg == ST_HIGH && high_cnt_reg != {COUNT_WIDTH{1'b1}}) begin
        high_cnt_reg <= high_cnt_reg + 1'b1;
      end
      if (!enable) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (rise) begin
              state_reg <= ST_HIGH;
              high_cnt_reg <= {COUNT_WIDTH{1'b0}};
              period_cnt_reg <= {COUNT_WIDTH{1'b0}};
            end
          end
          ST_HIGH: begin
            if (fall) begin
              high_capture_reg <= high_cnt_reg;
              state_reg <= ST_LOW;
            end
          end
          ST_LOW: begin
            if (rise) begin
              // period closes and the next measurement opens on the same edge
              period_capture_reg <= period_cnt_reg;
              capture_pulse <= 1'b1;
              high_cnt_reg <= {COUNT_WIDTH{1'b0}};
              period_cnt_reg <= {COUNT_WIDTH{1'b0}};
              state_reg <= ST_HIGH;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// [verif/spc_capture_chk.sv]
// port-level assertions for the pulse capture block
`timescale 1ns/1ps
module spc_capture_chk #(
  parameter COUNT_WIDTH = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] register_page_select,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire capture_input_pin_a,
  input wire capture_input_pin_b,
  input wire capture_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a control write carrying the flag-clear bit
  wire clr_wr = sfr_wr && clk_en && sfr_addr == 8'hDD && sfr_wdata[3];
  wire bad_rd = sfr_rd && clk_en && (register_page_select > 8'h01 || sfr_addr < 8'hD9 || sfr_addr > 8'hDD);
  // write, one quiet cycle, then a read of the same place
  sequence s_wr_rd(lo, hi);
    sfr_wr && clk_en && register_page_select < 8'h02 && sfr_addr >= lo && sfr_addr <= hi ##1 !sfr_wr ##1
      sfr_rd && clk_en && sfr_addr == $past(sfr_addr, 2) && register_page_select == $past(register_page_select, 2);
  endsequence
  sequence s_ctrl_rd;
    sfr_rd && clk_en && sfr_addr == 8'hDD && !clr_wr;
  endsequence
  a_rdata_holds: assert property (!(sfr_rd && clk_en) |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (bad_rd |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_reserved: assert property (sfr_rd && clk_en && sfr_addr == 8'hDD |=> !sfr_rdata[5] && !sfr_rdata[3])
    else $error("control bits 5 or 3 read as one");
  a_ctrl_readback: assert property (s_wr_rd(8'hDD, 8'hDD) |=> (sfr_rdata & 8'h97) == ($past(sfr_wdata, 3) & 8'h97))
    else $error("control field readback wrong");
  // a hardware latch may win over the byte write, and then raises the line
  a_count_readback: assert property (s_wr_rd(8'hD9, 8'hDC) |=> capture_irq || sfr_rdata == $past(sfr_wdata, 3))
    else $error("count byte readback wrong");
  a_irq_holds: assert property (capture_irq && !clr_wr |=> capture_irq)
    else $error("interrupt dropped without a clear");
  a_irq_clear_cause: assert property ($fell(capture_irq) |-> $past(clr_wr))
    else $error("interrupt fell with no clear write");
  a_done_drives_irq: assert property (s_ctrl_rd ##1 sfr_rdata[6] |-> capture_irq)
    else $error("done flag set but interrupt low");
endmodule
bind spc_capture spc_capture_chk #(.COUNT_WIDTH(COUNT_WIDTH)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .register_page_select(register_page_select),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .capture_input_pin_a(capture_input_pin_a), .capture_input_pin_b(capture_input_pin_b),
  .capture_irq(capture_irq));

// [verif/spc_pulse_src.sv]
// pulse source standing on the external capture pins
`timescale 1ns/1ps
module spc_pulse_src (
  input wire clk_sys,
  input wire go,
  input wire pin_sel,
  input wire [15:0] high_len,
  input wire [15:0] low_len,
  output wire pin_a,
  output wire pin_b
);
  reg level_reg = 1'b0;
  reg noise_reg = 1'b0;
  // unused pin chatters, so a wrong route ends in a bogus short capture
  always @(negedge clk_sys) noise_reg <= ~noise_reg;
  // two rises frame one full period; the second one closes the measurement
  always begin
    @(posedge go);
    repeat (2) begin
      level_reg = 1'b1;
      repeat (high_len) @(negedge clk_sys);
      level_reg = 1'b0;
      repeat (low_len) @(negedge clk_sys);
    end
  end
  assign pin_a = pin_sel ? level_reg : noise_reg;
  assign pin_b = pin_sel ? noise_reg : level_reg;
endmodule

// [verif/spc_capture_bench.sv]
// self-checking bench for the pulse capture block
`timescale 1ns/1ps
module spc_capture_bench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg clk_en = 1'b1;
  reg [7:0] page = 8'h00;
  reg [7:0] addr = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] wdata = 8'h00;
  reg go = 1'b0;
  reg pin_sel = 1'b0;
  wire [7:0] rdata;
  wire pin_a;
  wire pin_b;
  wire irq;
  reg [7:0] v8;
  reg [15:0] v16;
  reg [7:0] p;
  reg [7:0] a;
  reg [7:0] cs;
  integer n_mismatch = 0;
  integer checked = 0;
  integer cyc = 0;
  integer k;
  integer s;
  integer t;
  always #12.5 clk_sys = ~clk_sys;
  spc_capture u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .register_page_select(page),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .capture_input_pin_a(pin_a), .capture_input_pin_b(pin_b), .capture_irq(irq));
  spc_pulse_src u_src (.clk_sys(clk_sys), .go(go), .pin_sel(pin_sel), .high_len(16'h0028),
    .low_len(16'h003C), .pin_a(pin_a), .pin_b(pin_b));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (n_mismatch == 0 && checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // one-cycle strobes, so back-to-back calls sit two cycles apart
  task wr_reg(input [7:0] pg, input [7:0] ad, input [7:0] d);
    begin
      @(negedge clk_sys);
      page = pg;
      addr = ad;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_sys);
      wr = 1'b0;
    end
  endtask
  task rd_reg(input [7:0] pg, input [7:0] ad, output [7:0] d);
    begin
      @(negedge clk_sys);
      page = pg;
      addr = ad;
      rd = 1'b1;
      @(negedge clk_sys);
      rd = 1'b0;
      d = rdata;
    end
  endtask
  task rd_cnt(input [7:0] pg, input [7:0] ad, output [15:0] d);
    reg [7:0] lo;
    reg [7:0] hi;
    begin
      rd_reg(pg, ad, lo);
      rd_reg(pg, ad + 8'h01, hi);
      d = {hi, lo};
    end
  endtask
  // tick phase against the signal edges is free, so allow one tick either way
  function [15:0] near(input [15:0] x, input [15:0] e);
    near = {15'h0000, (x + 16'h0001 >= e) && (x <= e + 16'h0001)};
  endfunction
  task wait_irq;
    begin
      t = 0;
      while (irq !== 1'b1 && t < 3000) begin
        @(negedge clk_sys);
        t = t + 1;
      end
      chk({15'h0000, irq}, 16'h0001);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      stop_test;
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    // defaults on both pages, nothing on page 2
    for (p = 8'h00; p < 8'h03; p = p + 8'h01) begin
      for (a = 8'hD8; a < 8'hDF; a = a + 8'h01) begin
        rd_reg(p, a, v8);
        chk({8'h00, v8}, (p < 8'h02 && a == 8'hDD) ? 16'h0003 : 16'h0000);
      end
    end
    // a write with the clock enable low must be lost
    clk_en = 1'b0;
    wr_reg(8'h00, 8'hDD, 8'hFF);
    clk_en = 1'b1;
    rd_reg(8'h00, 8'hDD, v8);
    chk({8'h00, v8}, 16'h0003);
    wr_reg(8'h00, 8'hDD, 8'h17);
    rd_reg(8'h00, 8'hDD, v8);
    chk({8'h00, v8}, 16'h0017);
    for (p = 8'h00; p < 8'h02; p = p + 8'h01) begin
      for (a = 8'hD9; a < 8'hDD; a = a + 8'h01) begin
        wr_reg(p, a, a ^ {p[0], 7'h5A});
        rd_reg(p, a, v8);
        chk({8'h00, v8}, {8'h00, a ^ {p[0], 7'h5A}});
      end
    end
    rd_reg(8'h00, 8'hD9, v8);
    chk({8'h00, v8}, 16'h0083);
    // internal channel: level driven by bit 4, every clock code
    for (cs = 8'h00; cs < 8'h08; cs = cs + 8'h01) begin
      k = 4 << cs;
      wr_reg(8'h01, 8'hDD, 8'h80 | cs);
      wr_reg(8'h01, 8'hDD, 8'h90 | cs);
      repeat (6 * k) @(negedge clk_sys);
      wr_reg(8'h01, 8'hDD, 8'h80 | cs);
      repeat (4 * k) @(negedge clk_sys);
      wr_reg(8'h01, 8'hDD, 8'h90 | cs);
      wait_irq;
      rd_reg(8'h01, 8'hDD, v8);
      chk({8'h00, v8}, {8'h00, 8'hD0 | cs});
      rd_cnt(8'h01, 8'hDB, v16);
      chk(near(v16, 16'h0006), 16'h0001);
      rd_cnt(8'h01, 8'hD9, v16);
      chk(near(v16, 16'h000A), 16'h0001);
      wr_reg(8'h01, 8'hDD, 8'h90 | cs);
      chk({15'h0000, irq}, 16'h0001);
      wr_reg(8'h01, 8'hDD, 8'h08);
      chk({15'h0000, irq}, 16'h0000);
    end
    // external channel from the pulse source, both pin routes
    for (s = 0; s < 2; s = s + 1) begin
      pin_sel = s[0];
      wr_reg(8'h00, 8'hDD, {3'b100, s[0], 4'h0});
      go = 1'b1;
      wait_irq;
      go = 1'b0;
      rd_reg(8'h00, 8'hDD, v8);
      chk({8'h00, v8}, {8'h00, 3'b110, s[0], 4'h0});
      rd_reg(8'h01, 8'hDD, v8);
      chk({8'h00, v8}, 16'h0000);
      rd_cnt(8'h00, 8'hDB, v16);
      chk(near(v16, 16'h000A), 16'h0001);
      rd_cnt(8'h00, 8'hD9, v16);
      chk(near(v16, 16'h0019), 16'h0001);
      wr_reg(8'h01, 8'hDD, 8'h08);
      chk({15'h0000, irq}, 16'h0001);
      wr_reg(8'h00, 8'hDD, 8'h08);
      chk({15'h0000, irq}, 16'h0000);
      repeat (120) @(negedge clk_sys);
    end
    stop_test;
  end
endmodule
